// ---- bldec_agent.sv ----
`timescale 1ns/1ps
module bldec_agent (
	// clock
	input wire logic clk,
	// secondary bus agent lines
	output logic serr_n,
	output logic chk_valid,
	output logic chk_addr_phase,
	output logic [63:0] chk_ad,
	output logic [7:0] chk_cbe,
	output logic chk_par
);
	initial begin
		serr_n = 1'b1;
		chk_valid = 1'b0;
		chk_addr_phase = 1'b0;
		chk_ad = 64'h0;
		chk_cbe = 8'h0;
		chk_par = 1'b0;
	end
	// held low over several clocks, as a real agent does, to catch repeated messages
	task automatic pulse_serr;
		@(posedge clk);
		serr_n <= 1'b0;
		repeat (3) @(posedge clk);
		serr_n <= 1'b1;
	endtask : pulse_serr
	// bad turns the parity bit round on purpose
	task automatic phase(input logic ap, input logic [63:0] ad, input logic [7:0] cbe, input logic bad);
		@(posedge clk);
		chk_valid <= 1'b1;
		chk_addr_phase <= ap;
		chk_ad <= ad;
		chk_cbe <= cbe;
		chk_par <= ^{ad, cbe} ^ bad;
		@(posedge clk);
		chk_valid <= 1'b0;
		// released lines do not keep the last value
		chk_ad <= ~ad;
		chk_cbe <= ~cbe;
		chk_par <= ~chk_par;
	endtask : phase
endmodule : bldec_agent

// ---- bldec_decode.sv ----
`timescale 1ns/1ps
module bldec_decode import bldec_pkg::*; (
	// control
	input wire bldec_ctl_type ctl,
	input wire logic [31:0] io_base,
	input wire logic [31:0] io_limit,
	// requests
	input wire bldec_req_type dn_req,
	input wire bldec_req_type up_req,
	// decisions
	output logic dn_fwd,
	output logic dn_isa_blk,
	output logic up_fwd
);
	wire dn_vmem = !dn_req.is_io && dn_req.addr >= BLDEC_VMEM_LO && dn_req.addr <= BLDEC_VMEM_HI;
	wire up_vmem = !up_req.is_io && up_req.addr >= BLDEC_VMEM_LO && up_req.addr <= BLDEC_VMEM_HI;
	wire [9:0] dn_lo = dn_req.addr[9:0];
	wire [9:0] up_lo = up_req.addr[9:0];
	// full decode makes bits 15:10 count, so the 1 KB aliases stop matching
	wire dn_alias_ok = !ctl.video_io_full_decode_en || dn_req.addr[15:10] == 6'h00;
	wire up_alias_ok = !ctl.video_io_full_decode_en || up_req.addr[15:10] == 6'h00;
	wire dn_vio = dn_req.is_io && dn_req.addr[63:16] == 48'h0 && dn_alias_ok &&
		((dn_lo >= BLDEC_VIO_A_LO && dn_lo <= BLDEC_VIO_A_HI) || (dn_lo >= BLDEC_VIO_B_LO && dn_lo <= BLDEC_VIO_B_HI));
	wire up_vio = up_req.is_io && up_req.addr[63:16] == 48'h0 && up_alias_ok &&
		((up_lo >= BLDEC_VIO_A_LO && up_lo <= BLDEC_VIO_A_HI) || (up_lo >= BLDEC_VIO_B_LO && up_lo <= BLDEC_VIO_B_HI));
	wire dn_win = dn_req.is_io && dn_req.addr[63:32] == 32'h0 &&
		dn_req.addr[31:0] >= io_base && dn_req.addr[31:0] <= io_limit;
	wire dn_isa_hit = ctl.isa_en && dn_win && dn_req.addr[63:16] == 48'h0 && dn_req.addr[9:8] != 2'b00;
	wire dn_vga = ctl.vga_en && (dn_vmem ? ctl.mem_en : (dn_vio && ctl.io_en));

	assign dn_isa_blk = dn_isa_hit && !dn_vga;
	assign dn_fwd = dn_vga || (ctl.io_en && dn_win && !dn_isa_hit);
	// secondary I/O crosses only as the legacy video range; ISA filtering never looks here
	assign up_fwd = !ctl.vga_en && (up_vmem || up_vio);
endmodule : bldec_decode

// ---- bldec_parity.sv ----
`timescale 1ns/1ps
module bldec_parity import bldec_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// sourced cycles
	input wire logic src_valid,
	input wire logic [63:0] src_ad,
	input wire logic [7:0] src_cbe,
	output logic src_par,
	// received cycles
	input wire logic parity_err_response_en,
	input wire logic chk_valid,
	input wire logic chk_addr_phase,
	input wire logic [63:0] chk_ad,
	input wire logic [7:0] chk_cbe,
	input wire logic chk_par,
	output logic aperr,
	output logic dperr
);
	wire bad = chk_valid && (^{chk_ad, chk_cbe, chk_par});
	wire report = bad && parity_err_response_en;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_par <= 1'b0;
			aperr <= 1'b0;
			dperr <= 1'b0;
		end else begin
			// parity is produced whatever the response enable says
			if (src_valid) src_par <= ^{src_ad, src_cbe};
			aperr <= report && chk_addr_phase;
			dperr <= report && !chk_addr_phase;
		end
	end

	a_par_driven: assert property (@(posedge clk) disable iff (rst)
		src_valid |=> src_par == ^$past({src_ad, src_cbe})) else $error("sourced parity wrong");
	a_par_ignored: assert property (@(posedge clk) disable iff (rst)
		!parity_err_response_en |=> !aperr && !dperr) else $error("parity error reported while disabled");
	a_par_reported: assert property (@(posedge clk) disable iff (rst)
		chk_valid && parity_err_response_en && (^{chk_ad, chk_cbe, chk_par}) |=> aperr || dperr)
		else $error("parity error missed");
endmodule : bldec_parity

// ---- bldec_pkg.sv ----
package bldec_pkg;

	// register byte offsets on the AHB-Lite port
	localparam logic [7:0] BLDEC_OFS_BRCTL = 8'h00;
	localparam logic [7:0] BLDEC_OFS_CMD = 8'h04;
	localparam logic [7:0] BLDEC_OFS_IOBASE = 8'h08;
	localparam logic [7:0] BLDEC_OFS_IOLIMIT = 8'h0C;
	localparam logic [7:0] BLDEC_OFS_STATUS = 8'h10;
	localparam logic [7:0] BLDEC_OFS_MASK = 8'h14;

	// bridge_control field positions
	localparam int BLDEC_BC_PARITY_RESP = 0;
	localparam int BLDEC_BC_SERR_FWD = 1;
	localparam int BLDEC_BC_ISA = 2;
	localparam int BLDEC_BC_VGA = 3;
	localparam int BLDEC_BC_FULL_DECODE = 4;
	localparam logic [15:0] BLDEC_BC_WMASK = 16'h001F;

	// command register field positions
	localparam int BLDEC_CMD_IO = 0;
	localparam int BLDEC_CMD_MEM = 1;
	localparam int BLDEC_CMD_SERR = 8;
	localparam logic [15:0] BLDEC_CMD_WMASK = 16'h0103;

	// status / mask bit positions
	localparam int BLDEC_ST_SERR = 0;
	localparam int BLDEC_ST_APERR = 1;
	localparam int BLDEC_ST_DPERR = 2;
	localparam int BLDEC_ST_ISA = 3;
	localparam int BLDEC_ST_W = 4;

	// reset values; an empty I/O window has base above limit
	localparam logic [15:0] BLDEC_BRCTL_RST = 16'h0000;
	localparam logic [15:0] BLDEC_CMD_RST = 16'h0000;
	localparam logic [31:0] BLDEC_IOBASE_RST = 32'hFFFFFFFF;
	localparam logic [31:0] BLDEC_IOLIMIT_RST = 32'h00000000;
	localparam logic [3:0] BLDEC_ST_RST = 4'h0;

	// legacy video ranges
	localparam logic [63:0] BLDEC_VMEM_LO = 64'h00000000000A0000;
	localparam logic [63:0] BLDEC_VMEM_HI = 64'h00000000000BFFFF;
	localparam logic [9:0] BLDEC_VIO_A_LO = 10'h3B0;
	localparam logic [9:0] BLDEC_VIO_A_HI = 10'h3BB;
	localparam logic [9:0] BLDEC_VIO_B_LO = 10'h3C0;
	localparam logic [9:0] BLDEC_VIO_B_HI = 10'h3DF;

	typedef struct packed {
		logic video_io_full_decode_en;
		logic vga_en;
		logic isa_en;
		logic serr_fwd_en;
		logic parity_err_response_en;
		logic io_en;
		logic mem_en;
		logic serr_en;
	} bldec_ctl_type;

	typedef struct packed {
		logic is_io;
		logic [63:0] addr;
	} bldec_req_type;

endpackage : bldec_pkg

// ---- bldec_top.sv ----
// Operation
// - vga on forwards legacy video memory down
// - vga on forwards both video I/O ranges
// - video I/O: high bits zero, 15:10 aliased
// - memory/I/O enables qualify video forwarding
// - vga off sends secondary video accesses up
// - isa filter blocks upper 768 bytes per KB
// - filter only inside window, below 64 KB
// - secondary I/O never forwarded up otherwise
// - system error message needs three conditions
// - parity response off ignores parity errors
// - sourced cycles always carry correct parity
// - parity response on reports parity errors
`timescale 1ns/1ps
module bldec_top import bldec_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// primary-originated requests
	input wire logic dn_valid,
	input wire bldec_req_type dn_req,
	output logic dn_done,
	output logic dn_fwd,
	output logic dn_isa_blk,
	// secondary-originated requests
	input wire logic up_valid,
	input wire bldec_req_type up_req,
	output logic up_done,
	output logic up_fwd,
	// secondary system error
	input wire logic sec_serr_n,
	output logic syserr_msg,
	// secondary parity
	input wire logic src_valid,
	input wire logic [63:0] src_ad,
	input wire logic [7:0] src_cbe,
	output logic src_par,
	input wire logic chk_valid,
	input wire logic chk_addr_phase,
	input wire logic [63:0] chk_ad,
	input wire logic [7:0] chk_cbe,
	input wire logic chk_par,
	output logic perr_report,
	// interrupt
	output logic irq
);
	logic [15:0] brctl;
	logic [15:0] cmd;
	logic [31:0] io_base;
	logic [31:0] io_limit;
	logic [BLDEC_ST_W-1:0] status;
	logic [BLDEC_ST_W-1:0] mask;
	logic dph_wr;
	logic [7:0] dph_addr;
	logic serr_seen;
	logic dec_dn_fwd;
	logic dec_isa_blk;
	logic dec_up_fwd;
	logic aperr;
	logic dperr;
	bldec_ctl_type ctl;

	// control bits as the decode sees them
	assign ctl.video_io_full_decode_en = brctl[BLDEC_BC_FULL_DECODE];
	assign ctl.vga_en = brctl[BLDEC_BC_VGA];
	assign ctl.isa_en = brctl[BLDEC_BC_ISA];
	assign ctl.serr_fwd_en = brctl[BLDEC_BC_SERR_FWD];
	assign ctl.parity_err_response_en = brctl[BLDEC_BC_PARITY_RESP];
	assign ctl.io_en = cmd[BLDEC_CMD_IO];
	assign ctl.mem_en = cmd[BLDEC_CMD_MEM];
	assign ctl.serr_en = cmd[BLDEC_CMD_SERR];

	// bus decode
	wire ahb_take = hsel && htrans[1] && hready;
	wire ahb_rd = ahb_take && !hwrite;
	wire [7:0] a_ofs = haddr[7:0];
	wire wr_brctl = dph_wr && dph_addr == BLDEC_OFS_BRCTL;
	wire wr_cmd = dph_wr && dph_addr == BLDEC_OFS_CMD;
	wire wr_iobase = dph_wr && dph_addr == BLDEC_OFS_IOBASE;
	wire wr_iolimit = dph_wr && dph_addr == BLDEC_OFS_IOLIMIT;
	wire wr_mask = dph_wr && dph_addr == BLDEC_OFS_MASK;
	wire rd_status = ahb_rd && a_ofs == BLDEC_OFS_STATUS;
	wire [31:0] rd_data =
		(a_ofs == BLDEC_OFS_BRCTL) ? {16'h0000, brctl} :
		(a_ofs == BLDEC_OFS_CMD) ? {16'h0000, cmd} :
		(a_ofs == BLDEC_OFS_IOBASE) ? io_base :
		(a_ofs == BLDEC_OFS_IOLIMIT) ? io_limit :
		(a_ofs == BLDEC_OFS_STATUS) ? {28'h0000000, status} :
		(a_ofs == BLDEC_OFS_MASK) ? {28'h0000000, mask} : 32'h00000000;

	// events
	wire serr_rise = !sec_serr_n && !serr_seen;
	wire next_syserr = serr_rise && ctl.serr_fwd_en && ctl.serr_en;
	wire isa_event = dn_valid && dec_isa_blk;
	wire [BLDEC_ST_W-1:0] st_set = {isa_event, dperr, aperr, syserr_msg};
	// a set in the clearing read's cycle survives to the next read
	wire [BLDEC_ST_W-1:0] next_status = (rd_status ? BLDEC_ST_RST : status) | st_set;
	wire [BLDEC_ST_W-1:0] next_mask = wr_mask ? hwdata[BLDEC_ST_W-1:0] : mask;

	bldec_decode u_decode (
		.ctl(ctl),
		.io_base(io_base),
		.io_limit(io_limit),
		.dn_req(dn_req),
		.up_req(up_req),
		.dn_fwd(dec_dn_fwd),
		.dn_isa_blk(dec_isa_blk),
		.up_fwd(dec_up_fwd)
	);

	bldec_parity u_parity (
		.clk(clk),
		.rst(rst),
		.src_valid(src_valid),
		.src_ad(src_ad),
		.src_cbe(src_cbe),
		.src_par(src_par),
		.parity_err_response_en(ctl.parity_err_response_en),
		.chk_valid(chk_valid),
		.chk_addr_phase(chk_addr_phase),
		.chk_ad(chk_ad),
		.chk_cbe(chk_cbe),
		.chk_par(chk_par),
		.aperr(aperr),
		.dperr(dperr)
	);

	// bus slave: zero wait states, always OKAY
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dph_wr <= 1'b0;
			dph_addr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			dph_wr <= ahb_take && hwrite;
			if (ahb_take) dph_addr <= a_ofs;
			if (ahb_rd) hrdata <= rd_data;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// configuration registers; writes land in the data phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			brctl <= BLDEC_BRCTL_RST;
			cmd <= BLDEC_CMD_RST;
			io_base <= BLDEC_IOBASE_RST;
			io_limit <= BLDEC_IOLIMIT_RST;
		end else begin
			if (wr_brctl) brctl <= hwdata[15:0] & BLDEC_BC_WMASK;
			if (wr_cmd) cmd <= hwdata[15:0] & BLDEC_CMD_WMASK;
			if (wr_iobase) io_base <= hwdata;
			if (wr_iolimit) io_limit <= hwdata;
		end
	end

	// status, mask and interrupt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status <= BLDEC_ST_RST;
			mask <= BLDEC_ST_RST;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			mask <= next_mask;
			irq <= |(next_status & next_mask);
		end
	end

	// forwarding decisions, one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dn_done <= 1'b0;
			dn_fwd <= 1'b0;
			dn_isa_blk <= 1'b0;
			up_done <= 1'b0;
			up_fwd <= 1'b0;
		end else begin
			dn_done <= dn_valid;
			dn_fwd <= dn_valid && dec_dn_fwd;
			dn_isa_blk <= isa_event;
			up_done <= up_valid;
			up_fwd <= up_valid && dec_up_fwd;
		end
	end

	// one message per secondary SERR# assertion, not one per cycle it is held
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serr_seen <= 1'b0;
			syserr_msg <= 1'b0;
			perr_report <= 1'b0;
		end else begin
			serr_seen <= !sec_serr_n;
			syserr_msg <= next_syserr;
			perr_report <= aperr || dperr;
		end
	end

	// checks
	wire dn_in_vmem = !dn_req.is_io && dn_req.addr >= BLDEC_VMEM_LO && dn_req.addr <= BLDEC_VMEM_HI;
	wire dn_in_vio_b = dn_req.is_io && dn_req.addr[63:16] == 48'h0 &&
		dn_req.addr[9:0] >= BLDEC_VIO_B_LO && dn_req.addr[9:0] <= BLDEC_VIO_B_HI;
	wire up_in_vmem = !up_req.is_io && up_req.addr >= BLDEC_VMEM_LO && up_req.addr <= BLDEC_VMEM_HI;
	wire dn_in_vio_a = dn_req.is_io && dn_req.addr[63:16] == 48'h0 &&
		dn_req.addr[9:0] >= BLDEC_VIO_A_LO && dn_req.addr[9:0] <= BLDEC_VIO_A_HI;
	wire dn_in_win = dn_req.is_io && dn_req.addr[63:32] == 32'h0 &&
		dn_req.addr[31:0] >= io_base && dn_req.addr[31:0] <= io_limit;
	wire up_in_vio = up_req.is_io && up_req.addr[63:16] == 48'h0 &&
		(!ctl.video_io_full_decode_en || up_req.addr[15:10] == 6'h00) &&
		((up_req.addr[9:0] >= BLDEC_VIO_A_LO && up_req.addr[9:0] <= BLDEC_VIO_A_HI) ||
		(up_req.addr[9:0] >= BLDEC_VIO_B_LO && up_req.addr[9:0] <= BLDEC_VIO_B_HI));

	sequence s_serr_assert;
		sec_serr_n ##1 !sec_serr_n;
	endsequence

	sequence s_serr_allowed;
		ctl.serr_fwd_en && ctl.serr_en;
	endsequence

	sequence s_serr_hold;
		!sec_serr_n ##1 !sec_serr_n;
	endsequence

	a_vga_mem_fwd: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_in_vmem && ctl.vga_en && ctl.mem_en |=> dn_fwd && dn_done)
		else $error("legacy video memory not forwarded");
	a_vga_io_fwd: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_in_vio_b && !ctl.video_io_full_decode_en && ctl.vga_en && ctl.io_en |=> dn_fwd)
		else $error("legacy video I/O not forwarded");
	a_vga_io_high: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_req.is_io && dn_req.addr[63:32] != 32'h0 |=> !dn_fwd)
		else $error("video I/O matched with high address bits set");
	a_mem_gate: assert property (@(posedge clk) disable iff (rst)
		dn_valid && !dn_req.is_io && !ctl.mem_en |=> !dn_fwd)
		else $error("memory forwarded with memory decode off");
	a_io_gate: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_req.is_io && !ctl.io_en |=> !dn_fwd)
		else $error("I/O forwarded with I/O decode off");
	a_up_video: assert property (@(posedge clk) disable iff (rst)
		up_valid && up_in_vmem |=> up_fwd == !$past(ctl.vga_en))
		else $error("secondary video access direction wrong");
	a_isa_block: assert property (@(posedge clk) disable iff (rst)
		dn_isa_blk |-> !dn_fwd && $past(dn_req.addr[9:8]) != 2'b00)
		else $error("isa block wrong");
	a_isa_scope: assert property (@(posedge clk) disable iff (rst)
		dn_isa_blk |-> $past(dn_req.addr[63:16]) == 48'h0 && $past(ctl.isa_en))
		else $error("isa filter outside its scope");
	a_up_io_never: assert property (@(posedge clk) disable iff (rst)
		up_valid && up_req.is_io && ctl.vga_en |=> !up_fwd)
		else $error("secondary I/O forwarded up");
	a_serr_send: assert property (@(posedge clk) disable iff (rst)
		s_serr_assert ##0 s_serr_allowed |=> syserr_msg ##1 !syserr_msg)
		else $error("system error message not sent once");
	a_serr_cause: assert property (@(posedge clk) disable iff (rst)
		syserr_msg |-> $past(!sec_serr_n) && $past(ctl.serr_fwd_en) && $past(ctl.serr_en))
		else $error("system error message without cause");
	a_perr_quiet: assert property (@(posedge clk) disable iff (rst)
		!ctl.parity_err_response_en ##1 !ctl.parity_err_response_en |=> !perr_report)
		else $error("parity reported while response off");
	a_ctl_write: assert property (@(posedge clk) disable iff (rst)
		wr_brctl |=> brctl[3:0] == $past(hwdata[3:0]))
		else $error("bridge control write lost");
	a_mem_only_vga: assert property (@(posedge clk) disable iff (rst)
		dn_valid && !dn_req.is_io && !(dn_in_vmem && ctl.vga_en && ctl.mem_en) |=> !dn_fwd)
		else $error("memory forwarded outside legacy video");
	a_dn_idle: assert property (@(posedge clk) disable iff (rst)
		!dn_valid |=> !dn_done && !dn_fwd && !dn_isa_blk)
		else $error("downstream decision without request");
	a_vga_io_a: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_in_vio_a && !ctl.video_io_full_decode_en && ctl.vga_en && ctl.io_en |=> dn_fwd)
		else $error("first video I/O range not forwarded");
	a_full_decode: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_req.is_io && ctl.video_io_full_decode_en && dn_req.addr[15:10] != 6'h00 &&
		!dn_in_win |=> !dn_fwd)
		else $error("video I/O alias matched under full decode");
	a_up_vio: assert property (@(posedge clk) disable iff (rst)
		up_valid && up_in_vio |=> up_fwd == !$past(ctl.vga_en))
		else $error("secondary video I/O direction wrong");
	a_up_idle: assert property (@(posedge clk) disable iff (rst)
		!up_valid |=> !up_done && !up_fwd)
		else $error("upstream decision without request");
	a_isa_pass: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_in_win && dn_req.addr[9:8] == 2'b00 && ctl.io_en |=> dn_fwd)
		else $error("lower quarter of a 1 KB block not forwarded");
	a_isa_hit: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_in_win && ctl.isa_en && dn_req.addr[63:16] == 48'h0 && dn_req.addr[9:8] != 2'b00 &&
		!ctl.vga_en |=> dn_isa_blk && !dn_fwd)
		else $error("isa alias not blocked");
	a_isa_status: assert property (@(posedge clk) disable iff (rst)
		dn_isa_blk |-> status[BLDEC_ST_ISA])
		else $error("isa block not recorded");
	a_isa_outside: assert property (@(posedge clk) disable iff (rst)
		dn_valid && !dn_in_win |=> !dn_isa_blk)
		else $error("isa filter applied outside the window");
	a_isa_high: assert property (@(posedge clk) disable iff (rst)
		dn_valid && dn_req.addr[63:16] != 48'h0 |=> !dn_isa_blk)
		else $error("isa filter applied above 64 KB");
	a_up_io_other: assert property (@(posedge clk) disable iff (rst)
		up_valid && up_req.is_io && !up_in_vio |=> !up_fwd)
		else $error("secondary I/O outside video range forwarded up");
	a_serr_held: assert property (@(posedge clk) disable iff (rst)
		s_serr_hold |=> !syserr_msg)
		else $error("held system error sent again");
	a_serr_off: assert property (@(posedge clk) disable iff (rst)
		!(ctl.serr_fwd_en && ctl.serr_en) |=> !syserr_msg)
		else $error("system error message while disabled");
	a_serr_once: assert property (@(posedge clk) disable iff (rst)
		syserr_msg |=> !syserr_msg)
		else $error("system error message longer than one cycle");
	a_serr_status: assert property (@(posedge clk) disable iff (rst)
		syserr_msg |=> status[BLDEC_ST_SERR])
		else $error("system error message not recorded");
	a_par_hold: assert property (@(posedge clk) disable iff (rst)
		!src_valid |=> $stable(src_par))
		else $error("sourced parity changed without a cycle");
	a_par_clean: assert property (@(posedge clk) disable iff (rst)
		chk_valid && !(^{chk_ad, chk_cbe, chk_par}) |=> !aperr && !dperr)
		else $error("parity error on a clean phase");
	a_perr_path: assert property (@(posedge clk) disable iff (rst)
		aperr || dperr |=> perr_report)
		else $error("parity error not reported");
	a_aperr_status: assert property (@(posedge clk) disable iff (rst)
		aperr |=> status[BLDEC_ST_APERR])
		else $error("address parity error not recorded");
	a_dperr_status: assert property (@(posedge clk) disable iff (rst)
		dperr |=> status[BLDEC_ST_DPERR])
		else $error("data parity error not recorded");
	a_ctl_upper: assert property (@(posedge clk) disable iff (rst)
		brctl[15:5] == 11'h000)
		else $error("bridge control upper bits set");
	a_ctl_hold: assert property (@(posedge clk) disable iff (rst)
		!wr_brctl |=> $stable(brctl))
		else $error("bridge control changed without a write");
endmodule : bldec_top

// ---- bldec_top_bench.sv ----
`timescale 1ns/1ps
module bldec_top_bench import bldec_pkg::*;;
	logic clk, rst, hsel, hwrite, hreadyout, hresp;
	wire hready;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic dn_valid, up_valid, dn_done, dn_fwd, dn_isa_blk, up_done, up_fwd;
	bldec_req_type dn_req, up_req;
	logic sec_serr_n, syserr_msg, src_valid, src_par, chk_valid, chk_addr_phase, chk_par, perr_report, irq;
	logic [63:0] src_ad, chk_ad;
	logic [7:0] src_cbe, chk_cbe;
	int checks, miscompares, syserr_cnt, perr_cnt;

	assign hready = hreadyout;

	bldec_top u_dut (
		.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
		.dn_valid, .dn_req, .dn_done, .dn_fwd, .dn_isa_blk, .up_valid, .up_req, .up_done, .up_fwd,
		.sec_serr_n, .syserr_msg, .src_valid, .src_ad, .src_cbe, .src_par, .chk_valid, .chk_addr_phase,
		.chk_ad, .chk_cbe, .chk_par, .perr_report, .irq
	);

	bldec_agent u_agent (
		.clk, .serr_n(sec_serr_n), .chk_valid, .chk_addr_phase, .chk_ad, .chk_cbe, .chk_par
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// pulses are counted here so a doubled message is seen
	always @(negedge clk) begin
		if (syserr_msg === 1'b1) syserr_cnt++;
		if (perr_report === 1'b1) perr_cnt++;
	end

	task automatic results;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	task automatic cmpb(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t bit got %b exp %b", $time, g, e);
		end
	endtask : cmpb

	task automatic cmpw(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t word got %h exp %h", $time, g, e);
		end
	endtask : cmpw

	task automatic hwait;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (hready !== 1'b1) begin
			miscompares++;
			results();
		end
		cmpb(hresp, 1'b0);
	endtask : hwait

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		hwait();
		htrans <= 2'b00;
		hwdata <= d;
		hwait();
		r = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		cmpw(r, e);
	endtask : rd

	task automatic req(input logic up, input logic io, input logic [63:0] a, input logic ef, input logic eb);
		@(posedge clk);
		if (up) begin
			up_valid <= 1'b1;
			up_req <= {io, a};
		end else begin
			dn_valid <= 1'b1;
			dn_req <= {io, a};
		end
		@(posedge clk);
		dn_valid <= 1'b0;
		up_valid <= 1'b0;
		#1;
		cmpb(up ? up_done : dn_done, 1'b1);
		cmpb(up ? up_fwd : dn_fwd, ef);
		if (!up) cmpb(dn_isa_blk, eb);
	endtask : req

	task automatic src(input logic [63:0] ad, input logic [7:0] cbe);
		@(posedge clk);
		src_valid <= 1'b1;
		src_ad <= ad;
		src_cbe <= cbe;
		@(posedge clk);
		src_valid <= 1'b0;
		#1;
		cmpb(src_par, ^{ad, cbe});
	endtask : src

	task automatic t_regs;
		rd(BLDEC_OFS_BRCTL, 32'h0);
		wr(BLDEC_OFS_BRCTL, 32'hFFFFFFFF);
		rd(BLDEC_OFS_BRCTL, 32'h1F);
		wr(8'h18, 32'hFFFFFFFF);
		rd(8'h18, 32'h0);
		wr(BLDEC_OFS_BRCTL, 32'h0);
		rd(BLDEC_OFS_BRCTL, 32'h0);
	endtask : t_regs

	task automatic t_vmem;
		wr(BLDEC_OFS_CMD, 32'h2);
		wr(BLDEC_OFS_BRCTL, 32'h8);
		req(0, 0, 64'hA0000, 1, 0);
		req(0, 0, 64'hBFFFF, 1, 0);
		req(0, 0, 64'hC0000, 0, 0);
		req(1, 0, 64'hA0000, 0, 0);
		wr(BLDEC_OFS_CMD, 32'h0);
		req(0, 0, 64'hA0000, 0, 0);
		wr(BLDEC_OFS_BRCTL, 32'h0);
		req(1, 0, 64'hA0000, 1, 0);
		req(1, 1, 64'h3C0, 1, 0);
		req(1, 1, 64'h100, 0, 0);
	endtask : t_vmem

	task automatic t_vio;
		wr(BLDEC_OFS_CMD, 32'h1);
		wr(BLDEC_OFS_BRCTL, 32'h8);
		req(0, 1, 64'h3B0, 1, 0);
		req(0, 1, 64'h3BB, 1, 0);
		req(0, 1, 64'h3BC, 0, 0);
		req(0, 1, 64'h3DF, 1, 0);
		req(0, 1, 64'hFFC0, 1, 0);
		req(0, 1, 64'h103B0, 0, 0);
		req(0, 1, 64'h1000003B0, 0, 0);
		wr(BLDEC_OFS_BRCTL, 32'h18);
		req(0, 1, 64'h7B0, 0, 0);
		req(0, 1, 64'h3B0, 1, 0);
		wr(BLDEC_OFS_CMD, 32'h0);
		req(0, 1, 64'h3C0, 0, 0);
	endtask : t_vio

	task automatic t_isa;
		wr(BLDEC_OFS_IOBASE, 32'h0);
		wr(BLDEC_OFS_IOLIMIT, 32'h1FFFF);
		wr(BLDEC_OFS_CMD, 32'h1);
		wr(BLDEC_OFS_BRCTL, 32'h4);
		req(0, 1, 64'h0FF, 1, 0);
		req(0, 1, 64'h100, 0, 1);
		req(0, 1, 64'h7FF, 0, 1);
		req(0, 1, 64'h800, 1, 0);
		req(0, 1, 64'h10100, 1, 0);
		req(1, 1, 64'h100, 0, 0);
		rd(BLDEC_OFS_STATUS, 32'h8);
		rd(BLDEC_OFS_STATUS, 32'h0);
		wr(BLDEC_OFS_IOLIMIT, 32'h0);
		req(0, 1, 64'h100, 0, 0);
		wr(BLDEC_OFS_BRCTL, 32'h0);
	endtask : t_isa

	task automatic t_serr(input logic [31:0] cmd, input logic [31:0] bc, input int n);
		wr(BLDEC_OFS_MASK, 32'h1);
		wr(BLDEC_OFS_CMD, cmd);
		wr(BLDEC_OFS_BRCTL, bc);
		syserr_cnt = 0;
		u_agent.pulse_serr();
		repeat (4) @(posedge clk);
		#1;
		cmpb(syserr_cnt == n, 1'b1);
		cmpb(irq, n == 1);
		rd(BLDEC_OFS_STATUS, n);
		repeat (2) @(posedge clk);
		#1;
		cmpb(irq, 1'b0);
	endtask : t_serr

	task automatic t_par(input logic pe);
		wr(BLDEC_OFS_BRCTL, {31'h0, pe});
		wr(BLDEC_OFS_MASK, 32'h6);
		src(64'h1, 8'h0);
		src(64'h3, 8'h80);
		perr_cnt = 0;
		u_agent.phase(1'b1, 64'h1234, 8'h0F, 1'b1);
		repeat (4) @(posedge clk);
		#1;
		cmpb(perr_cnt == pe, 1'b1);
		cmpb(irq, pe);
		rd(BLDEC_OFS_STATUS, {29'h0, 1'b0, pe, 1'b0});
		u_agent.phase(1'b0, 64'hFFFF0000, 8'h33, 1'b1);
		u_agent.phase(1'b0, 64'h5, 8'h1, 1'b0);
		repeat (4) @(posedge clk);
		cmpb(perr_cnt == 2 * pe, 1'b1);
		rd(BLDEC_OFS_STATUS, {29'h0, pe, 2'b00});
	endtask : t_par

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		dn_valid = 1'b0;
		up_valid = 1'b0;
		dn_req = '0;
		up_req = '0;
		src_valid = 1'b0;
		src_ad = 64'h0;
		src_cbe = 8'h0;
		checks = 0;
		miscompares = 0;
		syserr_cnt = 0;
		perr_cnt = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_vmem();
		t_vio();
		t_isa();
		t_serr(32'h100, 32'h2, 1);
		t_serr(32'h100, 32'h0, 0);
		t_serr(32'h0, 32'h2, 0);
		t_par(1'b0);
		t_par(1'b1);
		results();
	end
endmodule : bldec_top_bench
